/* verilog/sms_pkg.sv */
package sms_pkg;

    // ****************************************
    // clock and intervals
    // ****************************************
    localparam int CLK_PERIOD_NS   = 5;
    localparam int RST_MIN_US      = 1000;    // least reset hold
    localparam int FAIL_PERSIST_US = 100000;  // main supply failure persistence
    localparam int CFG_TIMEOUT_US  = 75000;   // configuration wait timeout

    // least times round up to whole cycles
    localparam int RST_MIN_CYC  = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAIL_CYC     = (FAIL_PERSIST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CFG_TMO_CYC  = (CFG_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // wake sources, commands, bus modes
    // ****************************************
    localparam int WAKE_SRC_N = 5;  // bus, cyclic, permanent, forced, chip select

    localparam logic [1:0] CMD_NORMAL    = 2'h0;
    localparam logic [1:0] CMD_STANDBY   = 2'h1;
    localparam logic [1:0] CMD_SLEEP     = 2'h2;
    localparam logic [1:0] CMD_EMERGENCY = 2'h3;

    localparam logic [1:0] BUS_LOW_POWER = 2'h0;
    localparam logic [1:0] BUS_FULL      = 2'h1;
    localparam logic [1:0] BUS_LISTEN    = 2'h2;

    typedef enum logic [5:0] {
        ST_RESET   = 6'h01,
        ST_CFGWAIT = 6'h02,
        ST_NORMAL  = 6'h04,
        ST_STANDBY = 6'h08,
        ST_SLEEP   = 6'h10,
        ST_EMERG   = 6'h20
    } sms_mode_e;

endpackage

/* verilog/sms_interval_timer.sv */
`timescale 1ns/1ps
// saturating up counter; done holds once the count is reached
module sms_interval_timer #(
    parameter int CYC = 16
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      done
);
    localparam int W = $clog2(CYC + 1);
    localparam logic [W-1:0] LAST = W'(CYC);

    logic [W-1:0] cnt_q;

    // restart wins so a fresh mode entry never sees a stale count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (restart) begin
            cnt_q <= '0;
        end else if (cnt_q != LAST) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign done = (cnt_q == LAST) & ~restart;
endmodule // sms_interval_timer

/* verilog/sms_supply_decode.sv */
`timescale 1ns/1ps
// registered supply and reset-drive decode from the next mode
module sms_supply_decode (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire sms_pkg::sms_mode_e mode_d,
    input  wire logic              aux_enable,
    input  wire logic              bat_sw_sel,
    input  wire logic              cyclic_en,
    input  wire logic              cyclic_pulse,
    output logic                   main_on_q,
    output logic                   aux_on_q,
    output logic                   bat_sw_on_q,
    output logic                   rst_drive_q
);
    // ****************************************
    // per-mode supply decode
    // ****************************************
    wire is_rst  = (mode_d == sms_pkg::ST_RESET);
    wire is_cfg  = (mode_d == sms_pkg::ST_CFGWAIT);
    wire is_norm = (mode_d == sms_pkg::ST_NORMAL);
    wire is_stby = (mode_d == sms_pkg::ST_STANDBY);
    wire is_slp  = (mode_d == sms_pkg::ST_SLEEP);

    wire main_d  = is_rst | is_cfg | is_norm | is_stby;        // RULE4 RULE9 RULE11 RULE13 RULE15
    wire aux_d   = is_norm & aux_enable;                        // RULE8 RULE9 RULE11 RULE13
    wire bat_d   = ((is_norm | is_stby) & bat_sw_sel)           // RULE9 RULE11
                 | (is_slp & cyclic_en & cyclic_pulse);         // RULE13

    // all off at power-up; reset pin is pulled low from reset assertion, before any edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_on_q   <= 1'b0;
            aux_on_q    <= 1'b0;
            bat_sw_on_q <= 1'b0;
            rst_drive_q <= 1'b1;
        end else begin
            main_on_q   <= main_d;
            aux_on_q    <= aux_d;
            bat_sw_on_q <= bat_d;
            rst_drive_q <= is_rst;
        end
    end
endmodule // sms_supply_decode

/* verilog/sms_mode_sequencer.sv */
`timescale 1ns/1ps
// Contract
// RULE1: enter reset at power-up and on a bad watchdog trigger
// RULE2: hold reset the least interval, then go to config wait unless main supply failed
// RULE3: main supply low 100 ms after reset entry: sleep variant sleeps, other stays
// RULE4: config wait keeps main on, aux and battery switch off, loads defaults
// RULE5: no serial data 75 ms after reset release in config wait: go to sleep
// RULE6: watchdog timing word write arms the watchdog and enters normal
// RULE7: before timing word, config wait ignores every command but emergency
// RULE8: config wait keeps aux regulator and bus transmitter off
// RULE9: normal keeps main and aux on; battery switch as selected; here aux is on only while aux_enable is set
// RULE10: normal follows commands; watchdog timeout or main undervoltage goes via reset
// RULE11: standby by command: main on, aux off, battery switch fixed; watchdog served
// RULE12: standby leaves by command, or via reset on timeout, undervoltage, reset pin
// RULE13: sleep turns main and aux off; battery switch off or cyclic; command entry
// RULE14: sleep wakes to config wait on any of five wake sources
// RULE15: emergency by command: all supplies off, wakes ignored, leave on battery loss
// RULE16: full or listen bus modes only in normal; elsewhere bus low power
// RULE17: aux turn-off forces bus low power, not restored until rewritten
// RULE18: aux undervoltage holds bus in low power
// RULE19: trigger outside the enable window counts as watchdog failure
// RULE20: intervals counted from chip clock, restarted on mode entry
module sms_mode_sequencer #(
    parameter int RST_CYC     = sms_pkg::RST_MIN_CYC,
    parameter int FAIL_CYC    = sms_pkg::FAIL_CYC,
    parameter int CFG_CYC     = sms_pkg::CFG_TMO_CYC,
    parameter bit SLEEP_ON_FAIL = 1'b1,
    parameter int WAKE_N      = sms_pkg::WAKE_SRC_N
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // serial port decoded events
    input  wire logic              spi_frame,
    input  wire logic              cmd_valid,
    input  wire logic [1:0]        cmd_mode,
    input  wire logic              wd_timing_wr,
    input  wire logic              bus_mode_wr,
    input  wire logic [1:0]        bus_mode_wdata,
    input  wire logic              aux_enable,
    input  wire logic              bat_sw_sel,
    input  wire logic              cyclic_en,
    input  wire logic              cyclic_pulse,
    // watchdog
    input  wire logic              wd_trigger,
    input  wire logic              wd_in_window,
    input  wire logic              wd_timeout,
    // analog monitors and wakes
    input  wire logic              main_uv,
    input  wire logic              aux_uv,
    input  wire logic              battery_loss_event,
    input  wire logic [WAKE_N-1:0] wake_evt,
    // reset pin, open drain
    input  wire logic              reset_pin_n_i,
    output logic                   reset_pin_n_o,
    output logic                   reset_pin_n_oe,
    // supplies and status
    output logic                   main_regulator_out,
    output logic                   aux_regulator_out,
    output logic                   battery_switch_out,
    output logic [1:0]             bus_mode,
    output logic                   wd_active,
    output logic                   load_defaults,
    output sms_pkg::sms_mode_e     mode
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // two-stage release; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************
    // state
    // ****************************************
    sms_pkg::sms_mode_e state_q;
    sms_pkg::sms_mode_e state_d;
    logic               wd_active_q;
    logic               wd_active_d;
    logic               spi_seen_q;
    logic               spi_seen_d;
    logic               entry_q;
    logic [1:0]         bus_mode_q;
    logic [1:0]         bus_mode_d;
    logic [1:0]         bus_out_q;
    logic               rst_drive_q;
    logic               aux_on_q;
    logic               rst_done;
    logic               fail_done;
    logic               cfg_done;

    // ****************************************
    // decoded conditions
    // ****************************************
    wire in_rst  = (state_q == sms_pkg::ST_RESET);
    wire in_cfg  = (state_q == sms_pkg::ST_CFGWAIT);
    wire in_norm = (state_q == sms_pkg::ST_NORMAL);
    wire in_stby = (state_q == sms_pkg::ST_STANDBY);
    wire in_slp  = (state_q == sms_pkg::ST_SLEEP);
    wire in_emg  = (state_q == sms_pkg::ST_EMERG);

    wire wd_fail   = wd_active_q & (wd_timeout | (wd_trigger & ~wd_in_window)); // RULE1 RULE19
    wire ext_rst   = in_stby & ~reset_pin_n_i & ~rst_drive_q;                   // RULE12
    wire run_fail  = (in_norm | in_stby) & (wd_fail | main_uv | ext_rst);       // RULE10 RULE12
    wire cmd_emg   = cmd_valid & (cmd_mode == sms_pkg::CMD_EMERGENCY);
    wire cfg_tmo   = in_cfg & cfg_done & ~spi_seen_q;                           // RULE5
    wire any_wake  = |wake_evt;
    wire rst_fail  = in_rst & fail_done & main_uv;                              // RULE3

    // ****************************************
    // interval timers
    // ****************************************
    // one entry pulse restarts all three; each is read only in its own mode
    sms_interval_timer #(.CYC(RST_CYC)) u_rst_tmr (
        .clk     (clk_sys),
        .rst_n   (rst_n),
        .restart (entry_q),
        .done    (rst_done)
    ); // RULE20
    sms_interval_timer #(.CYC(FAIL_CYC)) u_fail_tmr (
        .clk     (clk_sys),
        .rst_n   (rst_n),
        .restart (entry_q),
        .done    (fail_done)
    );
    sms_interval_timer #(.CYC(CFG_CYC)) u_cfg_tmr (
        .clk     (clk_sys),
        .rst_n   (rst_n),
        .restart (entry_q),
        .done    (cfg_done)
    );

    // ****************************************
    // mode transitions
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            sms_pkg::ST_RESET: begin
                if (rst_done & ~main_uv) begin
                    state_d = sms_pkg::ST_CFGWAIT;                       // RULE2
                end else if (rst_fail & SLEEP_ON_FAIL) begin
                    state_d = sms_pkg::ST_SLEEP;                         // RULE3
                end
            end
            sms_pkg::ST_CFGWAIT: begin
                if (cmd_emg) begin
                    state_d = sms_pkg::ST_EMERG;                         // RULE7
                end else if (wd_timing_wr) begin
                    state_d = sms_pkg::ST_NORMAL;                        // RULE6
                end else if (cfg_tmo) begin
                    state_d = sms_pkg::ST_SLEEP;                         // RULE5
                end
            end
            sms_pkg::ST_NORMAL, sms_pkg::ST_STANDBY: begin
                if (run_fail) begin
                    state_d = sms_pkg::ST_RESET;                         // RULE10 RULE12
                end else if (cmd_valid) begin
                    case (cmd_mode)
                        sms_pkg::CMD_NORMAL:  state_d = sms_pkg::ST_NORMAL;
                        sms_pkg::CMD_STANDBY: state_d = sms_pkg::ST_STANDBY; // RULE11
                        sms_pkg::CMD_SLEEP:   state_d = sms_pkg::ST_SLEEP;   // RULE13
                        default:              state_d = sms_pkg::ST_EMERG;   // RULE15
                    endcase
                end
            end
            sms_pkg::ST_SLEEP: begin
                if (any_wake) begin
                    state_d = sms_pkg::ST_CFGWAIT;                       // RULE14
                end
            end
            sms_pkg::ST_EMERG: begin
                if (battery_loss_event) begin
                    state_d = sms_pkg::ST_RESET;                         // RULE15
                end
            end
            default: begin
                state_d = sms_pkg::ST_RESET;
            end
        endcase
    end

    // ****************************************
    // watchdog arm, serial-seen flag, bus mode
    // ****************************************
    // defaults are reloaded on every config-wait entry
    assign wd_active_d = (state_d == sms_pkg::ST_NORMAL) | (state_d == sms_pkg::ST_STANDBY);  // RULE6
    assign spi_seen_d  = (state_d != state_q) ? 1'b0 : (spi_seen_q | (in_cfg & spi_frame));   // RULE4 RULE5
    assign load_defaults = entry_q & in_cfg;                                                 // RULE4

    // writes only count once configured; losing aux or leaving normal clears the setting until it is rewritten
    assign bus_mode_d = (~aux_on_q | ~in_norm) ? sms_pkg::BUS_LOW_POWER                       // RULE17
                      : (bus_mode_wr & wd_active_q) ? bus_mode_wdata                           // RULE7
                      : bus_mode_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= sms_pkg::ST_RESET;                                // RULE1
            wd_active_q <= 1'b0;
            spi_seen_q  <= 1'b0;
            entry_q     <= 1'b1;
            bus_mode_q  <= sms_pkg::BUS_LOW_POWER;
        end else begin
            state_q     <= state_d;
            wd_active_q <= wd_active_d;
            spi_seen_q  <= spi_seen_d;
            entry_q     <= (state_d != state_q);                             // RULE20
            bus_mode_q  <= bus_mode_d;
        end
    end

    // transceiver mode seen outside; undervoltage on aux overrides everything
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_out_q <= sms_pkg::BUS_LOW_POWER;
        end else if ((state_d != sms_pkg::ST_NORMAL) | aux_uv | ~aux_on_q) begin
            bus_out_q <= sms_pkg::BUS_LOW_POWER;                              // RULE16 RULE18
        end else begin
            bus_out_q <= bus_mode_q;                                          // RULE16
        end
    end

    // ****************************************
    // supplies and reset pin
    // ****************************************
    sms_supply_decode u_supply (
        .clk          (clk_sys),
        .rst_n        (rst_n),
        .mode_d       (state_d),
        .aux_enable   (aux_enable),
        .bat_sw_sel   (bat_sw_sel),
        .cyclic_en    (cyclic_en),
        .cyclic_pulse (cyclic_pulse),
        .main_on_q    (main_regulator_out),
        .aux_on_q     (aux_on_q),
        .bat_sw_on_q  (battery_switch_out),
        .rst_drive_q  (rst_drive_q)
    );

    assign aux_regulator_out = aux_on_q;
    assign reset_pin_n_o     = 1'b0;          // open drain: only ever pulls low
    assign reset_pin_n_oe    = rst_drive_q;
    assign bus_mode          = bus_out_q;
    assign wd_active         = wd_active_q;
    assign mode              = state_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_wd_fail_reset: assert property (wd_active & wd_trigger & ~wd_in_window |=> mode == sms_pkg::ST_RESET) // RULE19
        else $error("bad trigger did not cause reset");
    a_reset_min_hold: assert property (in_rst ##1 !in_rst |-> $past(rst_done)) // RULE2
        else $error("reset left before least interval");
    a_reset_fail_var: assert property (in_rst & fail_done & main_uv
                                       |=> (SLEEP_ON_FAIL ? in_slp : in_rst)) // RULE3
        else $error("failure persistence handled wrong");
    a_cfg_supplies: assert property (in_cfg |-> main_regulator_out & ~aux_regulator_out & ~battery_switch_out) // RULE4
        else $error("config wait supplies wrong");
    a_cfg_timeout: assert property (in_cfg & cfg_done & ~spi_seen_q & ~wd_timing_wr & ~cmd_emg |=> in_slp) // RULE5
        else $error("config timeout not taken");
    a_cfg_arm: assert property (in_cfg & wd_timing_wr & ~cmd_emg |=> in_norm & wd_active ##1 aux_regulator_out == aux_enable) // RULE6
        else $error("timing word did not arm");
    a_cfg_ignore: assert property (in_cfg & cmd_valid & ~cmd_emg & ~wd_timing_wr & ~cfg_tmo |=> in_cfg) // RULE7
        else $error("command taken before timing word");
    a_norm_uv: assert property ((in_norm | in_stby) & main_uv |=> in_rst ##1 reset_pin_n_oe) // RULE10
        else $error("undervoltage did not reset");
    a_emerg_hold: assert property (in_emg & ~battery_loss_event |=> in_emg & ~main_regulator_out
                                   & ~aux_regulator_out & ~battery_switch_out) // RULE15
        else $error("emergency not kept");
    a_sleep_wake: assert property (in_slp & any_wake |=> in_cfg) // RULE14
        else $error("wake not taken from sleep");
    a_bus_forced: assert property (!in_norm |-> bus_mode == sms_pkg::BUS_LOW_POWER) // RULE16
        else $error("bus active outside normal");
    a_aux_uv_bus: assert property (aux_uv |=> bus_mode == sms_pkg::BUS_LOW_POWER) // RULE18
        else $error("bus active with aux low");
    a_aux_off_clr: assert property ($fell(aux_on_q) |=> bus_mode_q == sms_pkg::BUS_LOW_POWER) // RULE17
        else $error("bus setting survived aux off");

    c_reach_normal: cover property (in_cfg ##1 in_norm);
    c_cfg_to_sleep: cover property (in_cfg ##1 in_slp);
    c_emergency:    cover property (in_norm ##1 in_emg);
    c_standby_rst:  cover property (in_stby ##1 in_rst);
endmodule // sms_mode_sequencer

/* tb/sms_mcu_model.sv */
`timescale 1ns/1ps
// ****************************************
// microcontroller side of the serial port
// ****************************************
module sms_mcu_model (
    input  wire logic  clk_sys,
    output logic       spi_frame,
    output logic       cmd_valid,
    output logic [1:0] cmd_mode,
    output logic       wd_timing_wr,
    output logic       bus_mode_wr,
    output logic [1:0] bus_mode_wdata,
    output logic       wd_trigger
);
    // strobes idle low at time zero
    initial begin
        {spi_frame, cmd_valid, wd_timing_wr, bus_mode_wr, wd_trigger} = 5'h00;
        cmd_mode       = 2'h0;
        bus_mode_wdata = 2'h0;
    end

    // one frame: 0 command, 1 timing word, 2 bus mode, 3 watchdog trigger
    // data flips after the frame so a stale value never looks valid
    task automatic send(input int kind, input logic [1:0] val);
        @(negedge clk_sys);
        spi_frame      = 1'b1;
        cmd_mode       = val;
        bus_mode_wdata = val;
        cmd_valid      = (kind == 0);
        wd_timing_wr   = (kind == 1);
        bus_mode_wr    = (kind == 2);
        wd_trigger     = (kind == 3);
        @(negedge clk_sys);
        {spi_frame, cmd_valid, wd_timing_wr, bus_mode_wr, wd_trigger} = 5'h00;
        cmd_mode       = ~cmd_mode;
        bus_mode_wdata = ~bus_mode_wdata;
    endtask
endmodule // sms_mcu_model

/* tb/sms_mode_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %0t got %0h want %0h", $time, (a), (e)); end end
module sms_mode_sequencer_tb;
    // ****************************************
    // stimulus and wires
    // ****************************************
    logic clk_sys, nrst, aux_enable, bat_sw_sel, cyclic_en, cyclic_pulse, wd_in_window;
    logic wd_timeout, main_uv, aux_uv, battery_loss_event, ext_rst;
    logic [4:0] wake_evt;
    logic spi_frame, cmd_valid, wd_timing_wr, bus_mode_wr, wd_trigger;
    logic [1:0] cmd_mode, bus_mode_wdata, bus_mode;
    logic reset_pin_n_i, reset_pin_n_o, reset_pin_n_oe, wd_active, load_defaults;
    logic main_regulator_out, aux_regulator_out, battery_switch_out;
    sms_pkg::sms_mode_e mode;
    int num_errors, total_checks, n, ld_seen;
    logic [1:0] v;

    // pin is low if the device pulls it or the board asserts it, else pull-up
    assign reset_pin_n_i = ~((reset_pin_n_oe & ~reset_pin_n_o) | ext_rst);

    // short intervals keep the run small; expectations use the same figures
    sms_mode_sequencer #(.RST_CYC(20), .FAIL_CYC(200), .CFG_CYC(100), .SLEEP_ON_FAIL(1'b1))
    sms_mode_sequencer_inst (.clk_sys, .nrst, .spi_frame, .cmd_valid, .cmd_mode, .wd_timing_wr,
        .bus_mode_wr, .bus_mode_wdata, .aux_enable, .bat_sw_sel, .cyclic_en, .cyclic_pulse,
        .wd_trigger, .wd_in_window, .wd_timeout, .main_uv, .aux_uv, .battery_loss_event,
        .wake_evt, .reset_pin_n_i, .reset_pin_n_o, .reset_pin_n_oe, .main_regulator_out,
        .aux_regulator_out, .battery_switch_out, .bus_mode, .wd_active, .load_defaults, .mode);

    sms_mcu_model sms_mcu_model_inst (.clk_sys, .spi_frame, .cmd_valid, .cmd_mode, .wd_timing_wr,
        .bus_mode_wr, .bus_mode_wdata, .wd_trigger);

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // defaults pulse only in config wait
    always @(negedge clk_sys) begin
        if (load_defaults === 1'b1) begin
            ld_seen++;
            `CHK(mode, sms_pkg::ST_CFGWAIT)
        end
    end

    // ****************************************
    // expectations and helpers
    // ****************************************
    // {main, aux, battery switch}; cyclic sense stays off so sleep is all off
    function automatic logic [2:0] exp_sup(sms_pkg::sms_mode_e m, logic ae, logic bs);
        case (m)
            sms_pkg::ST_CFGWAIT: return 3'h4;
            sms_pkg::ST_NORMAL:  return {1'b1, ae, bs};
            sms_pkg::ST_STANDBY: return {2'b10, bs};
            default:             return 3'h0;
        endcase
    endfunction

    task automatic chk_sup();
        `CHK({main_regulator_out, aux_regulator_out, battery_switch_out}, exp_sup(mode, aux_enable, bat_sw_sel))
    endtask

    task automatic wait_mode(input sms_pkg::sms_mode_e m, input int lim, output int k);
        k = 0;
        while (mode !== m && k < lim) begin
            @(negedge clk_sys);
            k++;
        end
    endtask

    // one-cycle event: {main_uv, battery loss, watchdog timeout, wakes}
    task automatic bump(input logic [7:0] sel);
        @(negedge clk_sys);
        {main_uv, battery_loss_event, wd_timeout, wake_evt} = sel;
        @(negedge clk_sys);
        {main_uv, battery_loss_event, wd_timeout, wake_evt} = 8'h00;
    endtask

    task automatic do_reset();
        @(negedge clk_sys);
        nrst = 1'b0;
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
    endtask

    task automatic to_normal();
        wait_mode(sms_pkg::ST_CFGWAIT, 60, n);
        sms_mcu_model_inst.send(1, 2'h0);
        wait_mode(sms_pkg::ST_NORMAL, 5, n);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // far beyond the several hundred cycles the tests need
    initial begin
        #(5 * 20000);
        num_errors++;
        stop_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        {nrst, aux_enable, bat_sw_sel, cyclic_en, cyclic_pulse, wd_in_window} = 6'h10;
        {wd_timeout, main_uv, aux_uv, battery_loss_event, ext_rst, wake_evt} = 10'h000;
        {num_errors, total_checks, ld_seen} = 0;
        void'($urandom(32'h4d8419d2));
        do_reset();
        `CHK(mode, sms_pkg::ST_RESET)
        `CHK(reset_pin_n_oe, 1'b1)
        wait_mode(sms_pkg::ST_CFGWAIT, 60, n);
        `CHK(n >= 20, 1'b1)
        chk_sup();
        `CHK({bus_mode, wd_active}, 3'h0)
        $display("power-up reset done");
        // commands before the timing word are dropped
        for (int i = 0; i < 6; i++) begin
            sms_mcu_model_inst.send(i % 2 ? 0 : 2, 2'($urandom % 3));
            repeat (2) @(negedge clk_sys);
            `CHK({mode, bus_mode}, {sms_pkg::ST_CFGWAIT, sms_pkg::BUS_LOW_POWER})
        end
        `CHK(ld_seen > 0, 1'b1)
        sms_mcu_model_inst.send(1, 2'h0);
        wait_mode(sms_pkg::ST_NORMAL, 5, n);
        `CHK({mode, wd_active}, {sms_pkg::ST_NORMAL, 1'b1})
        for (int i = 0; i < 4; i++) begin
            bat_sw_sel = 1'($urandom);
            repeat (2) @(negedge clk_sys);
            chk_sup();
        end
        $display("configuration done");
        // bus modes in normal, undervoltage mask, aux turn-off
        for (int i = 1; i < 3; i++) begin
            v = 2'(i);
            sms_mcu_model_inst.send(2, v);
            repeat (3) @(negedge clk_sys);
            `CHK(bus_mode, v)
        end
        aux_uv = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(bus_mode, sms_pkg::BUS_LOW_POWER)
        aux_uv = 1'b0;
        aux_enable = 1'b0;
        repeat (3) @(negedge clk_sys);
        `CHK({aux_regulator_out, bus_mode}, {1'b0, sms_pkg::BUS_LOW_POWER})
        aux_enable = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(bus_mode, sms_pkg::BUS_LOW_POWER)
        sms_mcu_model_inst.send(2, sms_pkg::BUS_FULL);
        repeat (3) @(negedge clk_sys);
        `CHK(bus_mode, sms_pkg::BUS_FULL)
        $display("bus modes done");
        // standby, watchdog served in window, then board reset pin
        sms_mcu_model_inst.send(0, sms_pkg::CMD_STANDBY);
        wait_mode(sms_pkg::ST_STANDBY, 5, n);
        chk_sup();
        `CHK(bus_mode, sms_pkg::BUS_LOW_POWER)
        wd_in_window = 1'b1;
        sms_mcu_model_inst.send(3, 2'h0);
        repeat (5) @(negedge clk_sys);
        `CHK(mode, sms_pkg::ST_STANDBY)
        ext_rst = 1'b1;
        wait_mode(sms_pkg::ST_RESET, 5, n);
        `CHK(mode, sms_pkg::ST_RESET)
        ext_rst = 1'b0;
        wait_mode(sms_pkg::ST_CFGWAIT, 60, n);
        `CHK(mode, sms_pkg::ST_CFGWAIT)
        $display("standby done");
        // failures: timeout, trigger out of window, undervoltage, standby timeout
        for (int k = 0; k < 4; k++) begin
            to_normal();
            if (k == 3) begin
                sms_mcu_model_inst.send(0, sms_pkg::CMD_STANDBY);
                wait_mode(sms_pkg::ST_STANDBY, 5, n);
            end
            wd_in_window = 1'b0;
            if (k == 1)
                sms_mcu_model_inst.send(3, 2'h0);
            else
                bump(k == 2 ? 8'h80 : 8'h20);
            wait_mode(sms_pkg::ST_RESET, 5, n);
            `CHK(mode, sms_pkg::ST_RESET)
            wait_mode(sms_pkg::ST_CFGWAIT, 60, n);
            `CHK(mode, sms_pkg::ST_CFGWAIT)
        end
        $display("failures done");
        // sleep by command, each wake source
        for (int w = 0; w < 5; w++) begin
            to_normal();
            sms_mcu_model_inst.send(0, sms_pkg::CMD_SLEEP);
            wait_mode(sms_pkg::ST_SLEEP, 5, n);
            chk_sup();
            bump(8'(1 << w));
            wait_mode(sms_pkg::ST_CFGWAIT, 5, n);
            `CHK(mode, sms_pkg::ST_CFGWAIT)
        end
        // silent config wait falls asleep
        wait_mode(sms_pkg::ST_SLEEP, 200, n);
        `CHK({mode, n >= 95}, {sms_pkg::ST_SLEEP, 1'b1})
        $display("sleep done");
        // emergency ignores wakes, leaves on battery loss
        bump(8'h01);
        wait_mode(sms_pkg::ST_CFGWAIT, 5, n);
        sms_mcu_model_inst.send(0, sms_pkg::CMD_EMERGENCY);
        wait_mode(sms_pkg::ST_EMERG, 5, n);
        chk_sup();
        bump(8'h1f);
        repeat (3) @(negedge clk_sys);
        `CHK({mode, bus_mode}, {sms_pkg::ST_EMERG, sms_pkg::BUS_LOW_POWER})
        bump(8'h40);
        wait_mode(sms_pkg::ST_RESET, 5, n);
        `CHK(mode, sms_pkg::ST_RESET)
        $display("emergency done");
        // main supply stuck low at power-up
        main_uv = 1'b1;
        do_reset();
        wait_mode(sms_pkg::ST_SLEEP, 400, n);
        `CHK({mode, n >= 200}, {sms_pkg::ST_SLEEP, 1'b1})
        main_uv = 1'b0;
        $display("supply failure done");
        stop_test();
    end
endmodule // sms_mode_sequencer_tb
